/* rtl/tlr_pkg.sv */
package tlr_pkg;
    // Serial frame: read flag, 8-bit address, 16-bit data, msb first
    localparam int          FRAME_BITS    = 25;
    localparam int          CMD_BITS      = 9;
    localparam logic [7:0]  LCR_ADDR      = 8'h83;
    localparam logic [7:0]  LINE_ADDR     = 8'h84;
    localparam int          LCR_TOGGLE    = 15;
    localparam logic        LCR_RESET     = 1'b0;
    localparam logic [15:0] LCR_WMASK     = 16'h8000;
    localparam int          LINES_DEF     = 525;
    localparam int          BSR_W_DEF     = 16;
    localparam logic [1:0]  IR_SAMPLE     = 2'b01;
    localparam logic [1:0]  IR_BYPASS     = 2'b11;
    localparam logic [1:0]  IR_CAPT       = 2'b01;
    // Controller registers, byte addresses
    localparam logic [7:0]  A_CTRL        = 8'h00;
    localparam logic [7:0]  A_CMD         = 8'h04;
    localparam logic [7:0]  A_STAT        = 8'h08;
    localparam logic [7:0]  A_RDATA       = 8'h0c;
    localparam logic [7:0]  A_JTAG        = 8'h10;
    localparam int          CTRL_TEST     = 0;
    localparam int          CTRL_RST      = 1;
    localparam int          J_TMS         = 0;
    localparam int          J_TDI         = 1;
    localparam int          J_TDO         = 2;
    localparam int          CMD_RD        = 24;
    localparam int          SYS_CLK_KHZ   = 40000;
    localparam int          SYS_PERIOD_NS = 25;
    localparam int          RST_HOLD_US   = 500;
    localparam int          RST_HOLD_CYC  = (RST_HOLD_US * SYS_CLK_KHZ + 999) / 1000;
    localparam int          LINK_PERIOD_NS = 200;
    localparam int          LINK_HALF     = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_LOW  = 2'b01,
        HS_HIGH = 2'b10
    } tlr_hstate_t;

    typedef enum logic [3:0] {
        TS_RESET  = 4'b0000, TS_IDLE   = 4'b0001, TS_SEL_DR = 4'b0010, TS_CAP_DR = 4'b0011,
        TS_SH_DR  = 4'b0100, TS_EX1_DR = 4'b0101, TS_PA_DR  = 4'b0110, TS_EX2_DR = 4'b0111,
        TS_UPD_DR = 4'b1000, TS_SEL_IR = 4'b1001, TS_CAP_IR = 4'b1010, TS_SH_IR  = 4'b1011,
        TS_EX1_IR = 4'b1100, TS_PA_IR  = 4'b1101, TS_EX2_IR = 4'b1110, TS_UPD_IR = 4'b1111
    } tlr_tap_t;
endpackage

/* rtl/tlr_if.sv */
`timescale 1ns/1ps
interface tlr_if;
    logic hp_clk;    // Serial clock; test clock in test mode
    logic hp_din;    // Serial data in; test data in
    logic hp_dout;   // Serial data out; test data out
    logic hp_sel_n;  // Frame select, low active; test mode select
    logic test_sel;  // High: scan test, low: register access
    logic reset_n;   // Device reset; scan controller reset in test
    modport dev  (input hp_clk, hp_din, hp_sel_n, test_sel, reset_n, output hp_dout);
    modport host (output hp_clk, hp_din, hp_sel_n, test_sel, reset_n, input hp_dout);
endinterface

/* rtl/tlr_tap.sv */
`timescale 1ns/1ps
module tlr_tap #(
    parameter int BSR_W = tlr_pkg::BSR_W_DEF
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tck_rise,
    input  wire logic             tck_fall,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic [BSR_W-1:0] bsr_in,
    output logic                  tdo
);
    tlr_pkg::tlr_tap_t st_reg, st_next;
    logic [1:0]       ir_reg, ir_next, irs_reg, irs_next;
    logic [BSR_W-1:0] bsr_reg, bsr_next;
    logic             byp_reg, byp_next, tdo_reg, tdo_next;

    function automatic tlr_pkg::tlr_tap_t step(input tlr_pkg::tlr_tap_t s, input logic m);
        case (s)
            tlr_pkg::TS_RESET:  step = m ? tlr_pkg::TS_RESET  : tlr_pkg::TS_IDLE;
            tlr_pkg::TS_IDLE:   step = m ? tlr_pkg::TS_SEL_DR : tlr_pkg::TS_IDLE;
            tlr_pkg::TS_SEL_DR: step = m ? tlr_pkg::TS_SEL_IR : tlr_pkg::TS_CAP_DR;
            tlr_pkg::TS_CAP_DR: step = m ? tlr_pkg::TS_EX1_DR : tlr_pkg::TS_SH_DR;
            tlr_pkg::TS_SH_DR:  step = m ? tlr_pkg::TS_EX1_DR : tlr_pkg::TS_SH_DR;
            tlr_pkg::TS_EX1_DR: step = m ? tlr_pkg::TS_UPD_DR : tlr_pkg::TS_PA_DR;
            tlr_pkg::TS_PA_DR:  step = m ? tlr_pkg::TS_EX2_DR : tlr_pkg::TS_PA_DR;
            tlr_pkg::TS_EX2_DR: step = m ? tlr_pkg::TS_UPD_DR : tlr_pkg::TS_SH_DR;
            tlr_pkg::TS_SEL_IR: step = m ? tlr_pkg::TS_RESET  : tlr_pkg::TS_CAP_IR;
            tlr_pkg::TS_CAP_IR: step = m ? tlr_pkg::TS_EX1_IR : tlr_pkg::TS_SH_IR;
            tlr_pkg::TS_SH_IR:  step = m ? tlr_pkg::TS_EX1_IR : tlr_pkg::TS_SH_IR;
            tlr_pkg::TS_EX1_IR: step = m ? tlr_pkg::TS_UPD_IR : tlr_pkg::TS_PA_IR;
            tlr_pkg::TS_PA_IR:  step = m ? tlr_pkg::TS_EX2_IR : tlr_pkg::TS_PA_IR;
            tlr_pkg::TS_EX2_IR: step = m ? tlr_pkg::TS_UPD_IR : tlr_pkg::TS_SH_IR;
            default:            step = m ? tlr_pkg::TS_SEL_DR : tlr_pkg::TS_IDLE;
        endcase
    endfunction

    always_comb begin
        st_next  = st_reg;
        ir_next  = ir_reg;
        irs_next = irs_reg;
        bsr_next = bsr_reg;
        byp_next = byp_reg;
        tdo_next = tdo_reg;
        if (tck_rise) begin
            st_next = step(st_reg, tms);
            case (st_reg)
                tlr_pkg::TS_RESET:  ir_next = tlr_pkg::IR_BYPASS;
                tlr_pkg::TS_CAP_DR: begin
                    bsr_next = bsr_in;
                    byp_next = 1'b0;
                end
                tlr_pkg::TS_SH_DR: begin
                    if (ir_reg == tlr_pkg::IR_SAMPLE) begin
                        bsr_next = {tdi, bsr_reg[BSR_W-1:1]};
                    end else begin
                        byp_next = tdi;
                    end
                end
                tlr_pkg::TS_CAP_IR: irs_next = tlr_pkg::IR_CAPT;
                tlr_pkg::TS_SH_IR:  irs_next = {tdi, irs_reg[1]};
                tlr_pkg::TS_UPD_IR: ir_next = irs_reg;
                default: ;
            endcase
        end
        // Output changes on the falling edge so the far end samples a settled bit
        if (tck_fall) begin
            if (st_reg == tlr_pkg::TS_SH_DR) begin
                tdo_next = (ir_reg == tlr_pkg::IR_SAMPLE) ? bsr_reg[0] : byp_reg;
            end else if (st_reg == tlr_pkg::TS_SH_IR) begin
                tdo_next = irs_reg[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg  <= tlr_pkg::TS_RESET;
            ir_reg  <= tlr_pkg::IR_BYPASS;
            irs_reg <= 2'h0;
            bsr_reg <= '0;
            byp_reg <= 1'b0;
            tdo_reg <= 1'b0;
        end else begin
            st_reg  <= st_next;
            ir_reg  <= ir_next;
            irs_reg <= irs_next;
            bsr_reg <= bsr_next;
            byp_reg <= byp_next;
            tdo_reg <= tdo_next;
        end
    end

    assign tdo = tdo_reg;
endmodule // tlr_tap

/* rtl/tlr_device.sv */
`timescale 1ns/1ps
module tlr_device #(
    parameter int LINES = tlr_pkg::LINES_DEF,
    parameter int BSR_W = tlr_pkg::BSR_W_DEF
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    tlr_if.dev               LINK,
    input  wire logic        LINE_TICK,
    output logic [15:0]      LINE_COUNT,
    output logic [15:0]      FRAME_COUNT,
    output logic             TEST_MODE,
    output logic             COUNT_CLEAR
);
    localparam logic [4:0]  FB   = 5'(tlr_pkg::FRAME_BITS);
    localparam logic [4:0]  CB   = 5'(tlr_pkg::CMD_BITS);
    localparam logic [15:0] LAST = 16'(LINES - 1);
    localparam int          NS   = 5;
    localparam logic [NS-1:0] SYNC_RST = 5'h04;

    if (LINES < 2 || LINES > 65536 || BSR_W < 1 || BSR_W > 32) begin : g_bad_param
        $error("tlr_device: LINES or BSR_W out of range");
    end

    logic [NS-1:0] pin_in, meta_reg, sync_reg;
    logic          s_clk, s_din, s_sel_n, s_test, s_rstn;
    logic          clk_d_reg, rise, fall, host_rst, tap_rst, tap_tdo;

    assign pin_in = {LINK.hp_clk, LINK.hp_din, LINK.hp_sel_n, LINK.test_sel, LINK.reset_n};

    // Every pin crosses two flops before any logic looks at it
    for (genvar i = 0; i < NS; i++) begin : g_sync
        always_ff @(posedge SYS_CLK) begin
            if (RESET) begin
                meta_reg[i] <= SYNC_RST[i];
                sync_reg[i] <= SYNC_RST[i];
            end else begin
                meta_reg[i] <= pin_in[i];
                sync_reg[i] <= meta_reg[i];
            end
        end
    end

    assign s_clk   = sync_reg[4];
    assign s_din   = sync_reg[3];
    assign s_sel_n = sync_reg[2];
    assign s_test  = sync_reg[1];
    assign s_rstn  = sync_reg[0];
    assign rise    = s_clk & ~clk_d_reg;
    assign fall    = ~s_clk & clk_d_reg;

    assign host_rst = RESET | (~s_test & ~s_rstn);
    assign tap_rst  = RESET | ~s_test | ~s_rstn;

    logic [4:0]  cnt_reg, cnt_next;
    logic [23:0] sr_reg, sr_next;
    logic [15:0] rd_reg, rd_next, rdata;
    logic        sdo_reg, sdo_next, lcr_reg, lcr_next, clr_reg, clr_next;
    logic [15:0] line_reg, line_next, frame_reg, frame_next;
    logic        pin_reg, pin_next;

    function automatic logic [15:0] reg_read(input logic [7:0] a, input logic lcr,
                                             input logic [15:0] line);
        case (a)
            tlr_pkg::LCR_ADDR:  reg_read = {lcr, 15'h0000};
            tlr_pkg::LINE_ADDR: reg_read = line;
            default:            reg_read = 16'h0000;
        endcase
    endfunction

    assign rdata = reg_read(sr_reg[7:0], lcr_reg, line_reg);

    always_comb begin
        cnt_next = cnt_reg;
        sr_next  = sr_reg;
        rd_next  = rd_reg;
        sdo_next = sdo_reg;
        lcr_next = lcr_reg;
        clr_next = 1'b0;
        // Register port only while select is low; frozen during scan
        if (!s_test) begin
            if (s_sel_n) begin
                cnt_next = 5'h00;
            end else if (rise && cnt_reg < FB) begin
                sr_next  = {sr_reg[22:0], s_din};
                cnt_next = cnt_reg + 5'h01;
                if (cnt_reg == FB - 5'h01 && !sr_reg[23]
                    && sr_reg[22:15] == tlr_pkg::LCR_ADDR) begin
                    // Only bit 15 is kept; reserved bits are dropped
                    lcr_next = sr_reg[14];
                    clr_next = (sr_reg[14] != lcr_reg);
                end
            end else if (fall && cnt_reg == CB) begin
                sdo_next = sr_reg[8] ? rdata[15] : 1'b0;
                rd_next  = sr_reg[8] ? {rdata[14:0], 1'b0} : 16'h0000;
            end else if (fall && cnt_reg > CB) begin
                sdo_next = rd_reg[15];
                rd_next  = {rd_reg[14:0], 1'b0};
            end
        end
    end

    always_comb begin
        line_next  = line_reg;
        frame_next = frame_reg;
        if (clr_reg) begin
            line_next  = 16'h0000;
            frame_next = 16'h0000;
        end else if (LINE_TICK) begin
            if (line_reg == LAST) begin
                line_next  = 16'h0000;
                frame_next = frame_reg + 16'h0001;
            end else begin
                line_next = line_reg + 16'h0001;
            end
        end
        pin_next = s_test ? tap_tdo : sdo_reg;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            clk_d_reg <= 1'b0;
            pin_reg   <= 1'b0;
        end else begin
            clk_d_reg <= s_clk;
            pin_reg   <= pin_next;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (host_rst) begin
            cnt_reg   <= 5'h00;
            sr_reg    <= 24'h000000;
            rd_reg    <= 16'h0000;
            sdo_reg   <= 1'b0;
            lcr_reg   <= tlr_pkg::LCR_RESET;
            clr_reg   <= 1'b0;
            line_reg  <= 16'h0000;
            frame_reg <= 16'h0000;
        end else begin
            cnt_reg   <= cnt_next;
            sr_reg    <= sr_next;
            rd_reg    <= rd_next;
            sdo_reg   <= sdo_next;
            lcr_reg   <= lcr_next;
            clr_reg   <= clr_next;
            line_reg  <= line_next;
            frame_reg <= frame_next;
        end
    end

    // Scan chain sees only the counter state: low BSR_W bits of frame and line count, line count lowest
    logic [BSR_W-1:0] bsr_cap;
    assign bsr_cap = BSR_W'({frame_reg, line_reg});

    tlr_tap #(
        .BSR_W (BSR_W)
    ) u_tap (
        .clk      (SYS_CLK),
        .rst      (tap_rst),
        .tck_rise (rise & s_test),
        .tck_fall (fall & s_test),
        .tms      (s_sel_n),
        .tdi      (s_din),
        .bsr_in   (bsr_cap),
        .tdo      (tap_tdo)
    );

    assign LINK.hp_dout = pin_reg;
    assign LINE_COUNT   = line_reg;
    assign FRAME_COUNT  = frame_reg;
    assign TEST_MODE    = sync_reg[1];
    assign COUNT_CLEAR  = clr_reg;
endmodule // tlr_device

/* rtl/tlr_host.sv */
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tlr_host #(
    parameter int HALF     = tlr_pkg::LINK_HALF,
    parameter int RST_HOLD = tlr_pkg::RST_HOLD_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    tlr_if.host              LINK
);
    localparam logic [7:0] PH = 8'(HALF - 1);
    localparam logic [4:0] FB = 5'(tlr_pkg::FRAME_BITS);
    localparam int         FW = tlr_pkg::FRAME_BITS;

    if (HALF < 3 || HALF > 256 || RST_HOLD < 1) begin : g_bad_param
        $error("tlr_host: HALF must be 3..256, RST_HOLD at least 1");
    end

    logic meta_reg, dout_s_reg;
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            meta_reg   <= 1'b0;
            dout_s_reg <= 1'b0;
        end else begin
            meta_reg   <= LINK.hp_dout;
            dout_s_reg <= meta_reg;
        end
    end

    tlr_pkg::tlr_hstate_t st_reg, st_next;
    logic [7:0]    ph_reg, ph_next, awa_reg, awa_next;
    logic [4:0]    bits_reg, bits_next;
    logic [FW-1:0] tx_reg, tx_next;
    logic [15:0]   rx_reg, rx_next, wd16;
    logic [31:0]   hold_reg, hold_next, wd_reg, wd_next, rdat_reg, rdat_next;
    logic [3:0]    ws_reg, ws_next;
    logic [1:0]    ctrl_reg, ctrl_next;
    logic          jt_reg, jt_next, tdo_reg, tdo_next;
    logic          clk_reg, clk_next, din_reg, din_next, sel_reg, sel_next;
    logic          test_reg, test_next, rstn_reg, rstn_next;
    logic          awg_reg, awg_next, wg_reg, wg_next, bv_reg, bv_next, rv_reg, rv_next;
    logic          awr_reg, awr_next, wr_reg, wr_next, arr_reg, arr_next, busy;

    assign busy = (st_reg != tlr_pkg::HS_IDLE) || (hold_reg != 32'h0);
    // Reserved bits of the counter reset word always go out as zero
    assign wd16 = (wd_reg[23:16] == tlr_pkg::LCR_ADDR) ?
                  (wd_reg[15:0] & tlr_pkg::LCR_WMASK) : wd_reg[15:0];

    function automatic logic [31:0] reg_read(input logic [7:0] a);
        case (a)
            tlr_pkg::A_CTRL:  reg_read = {30'h0, ctrl_reg};
            tlr_pkg::A_STAT:  reg_read = {30'h0, hold_reg != 32'h0, busy};
            tlr_pkg::A_RDATA: reg_read = {16'h0, rx_reg};
            tlr_pkg::A_JTAG:  reg_read = {29'h0, tdo_reg, 2'h0};
            default:          reg_read = 32'h0;
        endcase
    endfunction

    always_comb begin
        {st_next, ph_next, bits_next, tx_next, rx_next} = {st_reg, ph_reg, bits_reg, tx_reg, rx_reg};
        {jt_next, tdo_next, clk_next, din_next, sel_next} = {jt_reg, tdo_reg, clk_reg, din_reg, sel_reg};
        {awa_next, wd_next, ws_next, ctrl_next, rdat_next} = {awa_reg, wd_reg, ws_reg, ctrl_reg, rdat_reg};
        {awg_next, wg_next, bv_next, rv_next} = {awg_reg, wg_reg, bv_reg, rv_reg};
        hold_next = (hold_reg != 32'h0) ? hold_reg - 32'h1 : hold_reg;
        test_next = (st_reg == tlr_pkg::HS_IDLE) ? ctrl_reg[tlr_pkg::CTRL_TEST] : test_reg;
        case (st_reg)
            tlr_pkg::HS_IDLE: begin
                clk_next = 1'b0;
                if (!test_reg) sel_next = 1'b1;
            end
            tlr_pkg::HS_LOW: begin
                if (ph_reg == 8'h00) begin
                    clk_next = 1'b1;
                    ph_next  = PH;
                    st_next  = tlr_pkg::HS_HIGH;
                end else ph_next = ph_reg - 8'h01;
            end
            tlr_pkg::HS_HIGH: begin
                if (ph_reg == 8'h00) begin
                    rx_next   = {rx_reg[14:0], dout_s_reg};
                    tdo_next  = dout_s_reg;
                    clk_next  = 1'b0;
                    bits_next = bits_reg - 5'h01;
                    if (bits_reg == 5'h01) begin
                        st_next = tlr_pkg::HS_IDLE;
                        if (!jt_reg) sel_next = 1'b1;
                    end else begin
                        st_next  = tlr_pkg::HS_LOW;
                        tx_next  = {tx_reg[FW-2:0], 1'b0};
                        din_next = tx_reg[FW-2];
                        ph_next  = PH;
                    end
                end else ph_next = ph_reg - 8'h01;
            end
            default: st_next = tlr_pkg::HS_IDLE;
        endcase
        if (S_AXI_AWVALID && awr_reg) begin
            awg_next = 1'b1;
            awa_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wr_reg) begin
            wg_next = 1'b1;
            wd_next = S_AXI_WDATA;
            ws_next = S_AXI_WSTRB;
        end
        if (bv_reg && S_AXI_BREADY) bv_next = 1'b0;
        if (awg_reg && wg_reg && !bv_reg) begin
            bv_next  = 1'b1;
            awg_next = 1'b0;
            wg_next  = 1'b0;
            if (ws_reg[0] && awa_reg == tlr_pkg::A_CTRL) ctrl_next = wd_reg[1:0];
            // Link orders are ignored while a transfer or power-up hold runs
            if (!busy && ws_reg == 4'hf && awa_reg == tlr_pkg::A_CMD && !test_reg) begin
                tx_next   = {wd_reg[tlr_pkg::CMD_RD], wd_reg[23:16], wd16};
                din_next  = wd_reg[tlr_pkg::CMD_RD];
                sel_next  = 1'b0;
                bits_next = FB;
                jt_next   = 1'b0;
                ph_next   = PH;
                st_next   = tlr_pkg::HS_LOW;
            end
            if (!busy && ws_reg[0] && awa_reg == tlr_pkg::A_JTAG && test_reg) begin
                tx_next   = {wd_reg[tlr_pkg::J_TDI], {(FW-1){1'b0}}};
                din_next  = wd_reg[tlr_pkg::J_TDI];
                sel_next  = wd_reg[tlr_pkg::J_TMS];
                bits_next = 5'h01;
                jt_next   = 1'b1;
                ph_next   = PH;
                st_next   = tlr_pkg::HS_LOW;
            end
        end
        if (rv_reg && S_AXI_RREADY) rv_next = 1'b0;
        if (S_AXI_ARVALID && arr_reg) begin
            rv_next   = 1'b1;
            rdat_next = reg_read(S_AXI_ARADDR);
        end
        rstn_next = (hold_next == 32'h0) && !ctrl_next[tlr_pkg::CTRL_RST];
        awr_next  = !awg_next && !bv_next;
        wr_next   = !wg_next && !bv_next;
        arr_next  = !rv_next;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st_reg   <= tlr_pkg::HS_IDLE;
            {ph_reg, bits_reg, tx_reg, rx_reg} <= '0;
            {jt_reg, tdo_reg, clk_reg, din_reg} <= '0;
            sel_reg  <= 1'b1;
            test_reg <= 1'b0;
            rstn_reg <= 1'b0;
            hold_reg <= 32'(RST_HOLD);
            {awa_reg, wd_reg, ws_reg, ctrl_reg, rdat_reg} <= '0;
            {awg_reg, wg_reg, bv_reg, rv_reg, awr_reg, wr_reg, arr_reg} <= '0;
        end else begin
            st_reg   <= st_next;
            {ph_reg, bits_reg, tx_reg, rx_reg} <= {ph_next, bits_next, tx_next, rx_next};
            {jt_reg, tdo_reg, clk_reg, din_reg} <= {jt_next, tdo_next, clk_next, din_next};
            sel_reg  <= sel_next;
            test_reg <= test_next;
            rstn_reg <= rstn_next;
            hold_reg <= hold_next;
            {awa_reg, wd_reg, ws_reg, ctrl_reg, rdat_reg} <=
                {awa_next, wd_next, ws_next, ctrl_next, rdat_next};
            {awg_reg, wg_reg, bv_reg, rv_reg} <= {awg_next, wg_next, bv_next, rv_next};
            {awr_reg, wr_reg, arr_reg} <= {awr_next, wr_next, arr_next};
        end
    end

    assign LINK.hp_clk   = clk_reg;
    assign LINK.hp_din   = din_reg;
    assign LINK.hp_sel_n = sel_reg;
    assign LINK.test_sel = test_reg;
    assign LINK.reset_n  = rstn_reg;
    assign S_AXI_AWREADY = awr_reg;
    assign S_AXI_WREADY  = wr_reg;
    assign S_AXI_BRESP   = 2'h0;
    assign S_AXI_BVALID  = bv_reg;
    assign S_AXI_ARREADY = arr_reg;
    assign S_AXI_RDATA   = rdat_reg;
    assign S_AXI_RRESP   = 2'h0;
    assign S_AXI_RVALID  = rv_reg;
endmodule // tlr_host

/* tb/tlr_monitor.sv */
`timescale 1ns/1ps
module tlr_monitor (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic hp_clk,
    input wire logic hp_din,
    input wire logic hp_sel_n,
    input wire logic test_sel,
    input wire logic reset_n
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    clk_high_a: assert property ($rose(hp_clk) |-> hp_clk[*4] ##1 !hp_clk)
        else $error("link clock high phase wrong");
    clk_low_a: assert property ($fell(hp_clk) |-> !hp_clk[*4])
        else $error("link clock low phase short");
    din_stable_a: assert property (hp_clk |-> $stable(hp_din))
        else $error("data moved while clock high");
    tms_stable_a: assert property (hp_clk |-> $stable(hp_sel_n))
        else $error("select moved while clock high");
    idle_clk_a: assert property (!test_sel && hp_sel_n |-> !hp_clk)
        else $error("link clock runs outside frame");
    hold_rst_a: assert property ($fell(RESET) |-> !reset_n[*8])
        else $error("device reset released early");
    frame_len_a: assert property ($fell(hp_sel_n) && !test_sel |-> ##[199:201] $rose(hp_sel_n))
        else $error("frame length wrong");
    sel_change_a: assert property ($changed(test_sel) |-> !hp_clk)
        else $error("mode changed mid clock");
endmodule // tlr_monitor

/* tb/test_test_port_and_line_counter_reset.sv */
`timescale 1ns/1ps
module test_test_port_and_line_counter_reset;
    logic        clk = 0, rst = 1, lt = 0, awv = 0, wv = 0, arv = 0, brd = 0, rrd = 0;
    logic        awr, wrd, bv, arr, rv, tm, cc;
    logic [1:0]  br, rr;
    logic [3:0]  ws = 4'hf;
    logic [7:0]  aa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, seed = 32'hf18e2094;
    logic [15:0] lc, fc, mlc = 16'h0;
    int          n_fail = 0, checked = 0, n_clr = 0, cyc = 0;
    tlr_if lnk();
    tlr_device #(.LINES(8)) i_tlr_device (.SYS_CLK(clk), .RESET(rst), .LINK(lnk),
        .LINE_TICK(lt), .LINE_COUNT(lc), .FRAME_COUNT(fc), .TEST_MODE(tm), .COUNT_CLEAR(cc));
    tlr_host #(.HALF(4), .RST_HOLD(20)) i_tlr_host (.SYS_CLK(clk), .RESET(rst),
        .S_AXI_AWADDR(aa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rrd), .LINK(lnk));
    tlr_monitor i_tlr_monitor (.SYS_CLK(clk), .RESET(rst), .hp_clk(lnk.hp_clk),
        .hp_din(lnk.hp_din), .hp_sel_n(lnk.hp_sel_n), .test_sel(lnk.test_sel),
        .reset_n(lnk.reset_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task final_report;
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // Ready is sampled before this edge's updates land, so no race
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        aa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        brd <= 1;
        // Each channel is released at its own take
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awr && !aw_ok) begin
                aw_ok = 1;
                awv <= 0;
            end
            if (wrd && !w_ok) begin
                w_ok = 1;
                wv <= 0;
            end
        end
        while (!bv) @(posedge clk);
        chk(br, 0);
        brd <= 0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        ara <= a;
        arv <= 1;
        rrd <= 1;
        @(posedge clk);
        while (!arr) @(posedge clk);
        arv <= 0;
        while (!rv) @(posedge clk);
        d = rdat;
        chk(rr, 0);
        rrd <= 0;
        @(posedge clk);
    endtask
    task idle;
        logic [31:0] s;
        do rd(tlr_pkg::A_STAT, s); while (s[1:0] != 2'h0);
    endtask
    task lnk_cmd(input logic [24:0] c);
        wr(tlr_pkg::A_CMD, {7'h0, c});
        idle();
    endtask
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        lt <= rnd() % 8 == 0;
        n_clr <= n_clr + (cc === 1'b1);
        cyc <= cyc + 1;
        mlc <= (cc === 1'b1) ? 16'h0 : !lt ? mlc : (mlc == 16'h7) ? 16'h0 : mlc + 16'h1;
        if (cyc == 40000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        logic [31:0] d, v;
        logic        st;
        int          ex;
        st = 0;
        ex = 0;
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(tlr_pkg::A_STAT, d);
        chk(d[1], 1);
        idle();
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            // Corner: rewriting the stored value must not clear
            if (i == 1) v[15] = st;
            // Corner: a write without full strobes must be refused
            if (i == 2) ws <= 4'h7;
            lnk_cmd({1'b0, tlr_pkg::LCR_ADDR, v[15:0]});
            ws <= 4'hf;
            if (v[15] != st && i != 2) ex++;
            if (i != 2) st = v[15];
            chk(n_clr, ex);
            if (ex > 0) chk(lc, mlc);
            lnk_cmd({1'b1, tlr_pkg::LCR_ADDR, 16'h0});
            rd(tlr_pkg::A_RDATA, d);
            chk(d[15:0], {st, 15'h0});
        end
        wr(tlr_pkg::A_CTRL, 2);
        repeat (4) @(posedge clk);
        wr(tlr_pkg::A_CTRL, 0);
        chk(fc, 0);
        wr(tlr_pkg::A_CTRL, 1);
        idle();
        repeat (200) @(posedge clk);
        chk(tm, 1);
        wr(tlr_pkg::A_CTRL, 3);
        repeat (4) @(posedge clk);
        wr(tlr_pkg::A_CTRL, 1);
        repeat (4) @(posedge clk);
        chk(fc != 0, 1);
        for (int j = 0; j < 12; j++) begin
            wr(tlr_pkg::A_JTAG, {30'h0, j > 8, 1'((12'h05f >> j) & 12'h001)});
            idle();
        end
        rd(tlr_pkg::A_JTAG, d);
        chk(d[2], 1);
        wr(tlr_pkg::A_CTRL, 0);
        idle();
        repeat (4) @(posedge clk);
        chk(tm, 0);
        rd(8'h1c, d);
        chk(d, 0);
        final_report();
    end
endmodule // test_test_port_and_line_counter_reset
